// ==== hdl/input_lock_sync_monitor.sv ====
// ==========================================
// Notes on behaviour
// ==========================================
`include "lock_sync_defines.svh"

module input_lock_sync_monitor #(
	parameter int ADDR_W = 8,
	parameter int PER_W = 16,
	parameter int MC_MIN_PER = (`CLK_HZ + `MC_MAX_HZ - 1) / `MC_MAX_HZ,
	parameter int MC_MAX_PER = `CLK_HZ / `MC_MIN_HZ,
	parameter int IEC_MIN_PER = (`CLK_HZ + `IEC_MAX_HZ - 1) / `IEC_MAX_HZ,
	parameter int IEC_MAX_PER = `CLK_HZ / `IEC_MIN_HZ,
	parameter int DIV_MIN = (`CLK_HZ + `INT_MAX_HZ - 1) / `INT_MAX_HZ,
	parameter int DIV_MAX = `CLK_HZ / `INT_MIN_HZ,
	parameter int DIV_DEF = `CLK_HZ / `INT_DEF_HZ,
	parameter int TOL = `LOCK_TOL_CYC,
	parameter int WIN_CYCLES = `CLK_HZ / `MS_PER_S * `WIN_MS,
	parameter int BLINK_CYCLES = `CLK_HZ / `MS_PER_S * `BLINK_MS
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic mc_clk_in,
	input wire logic iec_clk_in,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic led_mc,
	output logic led_iec,
	output logic led_sync,
	output logic irq
);
	// ==========================================
	// elaboration checks and widths
	// ==========================================
	localparam int CNT_W = $clog2(WIN_CYCLES + 1);
	localparam int BLK_W = $clog2(BLINK_CYCLES + 1);
	localparam logic [CNT_W-1:0] WIN_LAST = CNT_W'(WIN_CYCLES - 1);
	localparam logic [BLK_W-1:0] BLK_LAST = BLK_W'(BLINK_CYCLES - 1);
	localparam logic [PER_W-1:0] DIV_LO = PER_W'(DIV_MIN);
	localparam logic [PER_W-1:0] DIV_HI = PER_W'(DIV_MAX);
	localparam logic [PER_W-1:0] DIV_RST = PER_W'(DIV_DEF);

	if (ADDR_W < 5 || PER_W > 32 || DIV_MIN < 2 || DIV_MIN > DIV_MAX ||
		DIV_DEF < DIV_MIN || DIV_DEF > DIV_MAX || DIV_MAX >= (1 << PER_W) ||
		WIN_CYCLES < 2 || BLINK_CYCLES < 2) begin : g_bad
		$error("input_lock_sync_monitor: parameters out of range");
	end

	// ==========================================
	// decode helpers
	// ==========================================
	// word match of an address against a register offset
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		hit = a[ADDR_W-1:2] == ADDR_W'(off) >> 2;
	endfunction : hit

	// state code from lock and sync flags
	function automatic lock_sync_pkg::lock_code_e code_of(input logic lk, input logic sy);
		code_of = !lk ? lock_sync_pkg::CODE_NOLOCK :
			(sy ? lock_sync_pkg::CODE_SYNC : lock_sync_pkg::CODE_LOCK);
	endfunction : code_of

	// led level: off, flashing or steady
	function automatic logic led_of(input lock_sync_pkg::lock_code_e c, input logic bl);
		led_of = (c == lock_sync_pkg::CODE_SYNC) | ((c == lock_sync_pkg::CODE_LOCK) & bl);
	endfunction : led_of

	// ==========================================
	// input meters
	// ==========================================
	logic mc_edge, mc_locked, iec_edge, iec_locked;
	logic [PER_W-1:0] mc_per, iec_per;

	rate_meter #(.MIN_PER(MC_MIN_PER), .MAX_PER(MC_MAX_PER), .TOL(TOL), .PER_W(PER_W)) u_mc (
		.sys_clk(sys_clk), .rst(rst), .pin(mc_clk_in),
		.edge_p(mc_edge), .locked(mc_locked), .period(mc_per));
	rate_meter #(.MIN_PER(IEC_MIN_PER), .MAX_PER(IEC_MAX_PER), .TOL(TOL), .PER_W(PER_W)) u_iec (
		.sys_clk(sys_clk), .rst(rst), .pin(iec_clk_in),
		.edge_p(iec_edge), .locked(iec_locked), .period(iec_per));

	// ==========================================
	// control registers and internal clock
	// ==========================================
	lock_sync_pkg::src_sel_e src_r; // chosen sample clock source
	logic [PER_W-1:0] div_r; // internal sample period in cycles
	logic [PER_W-1:0] int_cnt_r; // internal divider count
	logic int_tick_r; // one pulse per internal sample
	logic [`IRQ_W-1:0] irq_stat_r, irq_mask_r;

	// active sample tick; unlocked external choice falls back to internal
	wire use_mc = (src_r == lock_sync_pkg::SRC_MC) & mc_locked;
	wire use_iec = (src_r == lock_sync_pkg::SRC_IEC) & iec_locked;
	wire act_tick = use_mc ? mc_edge : (use_iec ? iec_edge : int_tick_r);
	wire act_lock = (src_r == lock_sync_pkg::SRC_INT) | use_mc | use_iec;

	// internal oscillator divided down to the sample rate
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			int_cnt_r <= {{(PER_W-1){1'b0}}, 1'b1};
			int_tick_r <= 1'b0;
		end else begin
			int_tick_r <= int_cnt_r >= div_r;
			int_cnt_r <= (int_cnt_r >= div_r) ? {{(PER_W-1){1'b0}}, 1'b1} : int_cnt_r + 1'b1;
		end
	end

	// ==========================================
	// synchronicity over a fixed window
	// ==========================================
	logic [CNT_W-1:0] win_cnt_r, mc_cnt_r, iec_cnt_r, act_cnt_r;
	logic mc_sync_r, iec_sync_r;
	wire win_end = win_cnt_r == WIN_LAST;
	wire [CNT_W-1:0] mc_tot = mc_cnt_r + CNT_W'(mc_edge);
	wire [CNT_W-1:0] iec_tot = iec_cnt_r + CNT_W'(iec_edge);
	wire [CNT_W-1:0] act_tot = act_cnt_r + CNT_W'(act_tick);

	// count frame and sample periods; compare at the window end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			win_cnt_r <= '0;
			mc_cnt_r <= '0;
			iec_cnt_r <= '0;
			act_cnt_r <= '0;
		end else begin
			win_cnt_r <= win_end ? '0 : win_cnt_r + 1'b1;
			mc_cnt_r <= win_end ? '0 : mc_tot;
			iec_cnt_r <= win_end ? '0 : iec_tot;
			act_cnt_r <= win_end ? '0 : act_tot;
		end
	end

	// sync only while locked and the counts matched exactly
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mc_sync_r <= 1'b0;
			iec_sync_r <= 1'b0;
		end else begin
			mc_sync_r <= mc_locked & (win_end ? (mc_tot == act_tot) : mc_sync_r);
			iec_sync_r <= iec_locked & (win_end ? (iec_tot == act_tot) : iec_sync_r);
		end
	end

	// ==========================================
	// state codes and indicators
	// ==========================================
	lock_sync_pkg::lock_code_e mc_code, iec_code;
	assign mc_code = code_of(mc_locked, mc_sync_r);
	assign iec_code = code_of(iec_locked, iec_sync_r);
	// every clock in use must agree for the master indicator
	wire msync = act_lock & (~mc_locked | mc_sync_r) & (~iec_locked | iec_sync_r);

	logic [BLK_W-1:0] blk_cnt_r; // flash phase counter
	logic blink_r; // flash pattern

	// flash pattern shared by all indicators
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			blk_cnt_r <= '0;
			blink_r <= 1'b0;
		end else begin
			blk_cnt_r <= (blk_cnt_r == BLK_LAST) ? '0 : blk_cnt_r + 1'b1;
			blink_r <= blink_r ^ (blk_cnt_r == BLK_LAST);
		end
	end

	// indicator outputs
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			led_mc <= 1'b0;
			led_iec <= 1'b0;
			led_sync <= 1'b0;
		end else begin
			led_mc <= led_of(mc_code, blink_r);
			led_iec <= led_of(iec_code, blink_r);
			led_sync <= msync | blink_r;
		end
	end

	// ==========================================
	// interrupt events
	// ==========================================
	logic mc_prev_r, iec_prev_r, msync_prev_r;
	wire [`IRQ_W-1:0] irq_ev = {msync ^ msync_prev_r, iec_locked ^ iec_prev_r,
		mc_locked ^ mc_prev_r};

	// ==========================================
	// register bus write side
	// ==========================================
	logic aw_held_r, w_held_r;
	logic [ADDR_W-1:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	wire wr_go = aw_held_r & w_held_r & ~s_axi_bvalid;
	wire [31:0] wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
	wire [31:0] wd = w_data_r & wmask;
	wire wr_ctrl = wr_go & hit(aw_addr_r, `REG_CTRL);
	wire wr_div = wr_go & hit(aw_addr_r, `REG_DIV);
	wire wr_istat = wr_go & hit(aw_addr_r, `REG_IRQ_STAT);
	wire wr_imask = wr_go & hit(aw_addr_r, `REG_IRQ_MASK);
	wire wr_ok = wr_ctrl | wr_div | wr_istat | wr_imask | hit(aw_addr_r, `REG_STATUS) |
		hit(aw_addr_r, `REG_MC_PER) | hit(aw_addr_r, `REG_IEC_PER);
	wire [PER_W-1:0] div_new = (div_r & ~wmask[PER_W-1:0]) | wd[PER_W-1:0];
	wire [`SRC_W-1:0] src_new = (src_r & ~wmask[`SRC_W-1:0]) | wd[`SRC_W-1:0];
	wire div_legal = (div_new >= DIV_LO) && (div_new <= DIV_HI);
	wire src_legal = src_new <= lock_sync_pkg::SRC_IEC;
	// hardware set wins over the software clear
	wire [`IRQ_W-1:0] irq_stat_nxt = (irq_stat_r & ~(wr_istat ? wd[`IRQ_W-1:0] : '0)) | irq_ev;

	// address and data are caught in either order, then answered together
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= '0;
			w_data_r <= '0;
			w_strb_r <= '0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// writable registers; illegal source or rate values are refused
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			src_r <= lock_sync_pkg::SRC_INT;
			div_r <= DIV_RST;
			irq_mask_r <= `IRQ_MASK_RST;
			irq_stat_r <= '0;
			mc_prev_r <= 1'b0;
			iec_prev_r <= 1'b0;
			msync_prev_r <= 1'b1; // master sync idles high after reset: no false event
			irq <= 1'b0;
		end else begin
			if (wr_ctrl && src_legal) begin
				src_r <= lock_sync_pkg::src_sel_e'(src_new);
			end
			if (wr_div && div_legal) begin
				div_r <= div_new;
			end
			if (wr_imask) begin
				irq_mask_r <= (irq_mask_r & ~wmask[`IRQ_W-1:0]) | wd[`IRQ_W-1:0];
			end
			irq_stat_r <= irq_stat_nxt;
			mc_prev_r <= mc_locked;
			iec_prev_r <= iec_locked;
			msync_prev_r <= msync;
			irq <= |(irq_stat_nxt & irq_mask_r);
		end
	end

	// ==========================================
	// register bus read side
	// ==========================================
	wire [31:0] st_word = (32'(act_lock) << `ST_ACT_LOCK) | (32'(msync) << `ST_MSYNC) |
		(32'(iec_code) << `ST_IEC_LSB) | (32'(mc_code) << `ST_MC_LSB);
	wire ar_ok = hit(s_axi_araddr, `REG_CTRL) | hit(s_axi_araddr, `REG_DIV) |
		hit(s_axi_araddr, `REG_STATUS) | hit(s_axi_araddr, `REG_IRQ_STAT) |
		hit(s_axi_araddr, `REG_IRQ_MASK) | hit(s_axi_araddr, `REG_MC_PER) |
		hit(s_axi_araddr, `REG_IEC_PER);
	wire [31:0] rd_mux =
		hit(s_axi_araddr, `REG_CTRL) ? 32'(src_r) :
		hit(s_axi_araddr, `REG_DIV) ? 32'(div_r) :
		hit(s_axi_araddr, `REG_STATUS) ? st_word :
		hit(s_axi_araddr, `REG_IRQ_STAT) ? 32'(irq_stat_r) :
		hit(s_axi_araddr, `REG_IRQ_MASK) ? 32'(irq_mask_r) :
		hit(s_axi_araddr, `REG_MC_PER) ? 32'(mc_per) :
		hit(s_axi_araddr, `REG_IEC_PER) ? 32'(iec_per) : 32'h0000_0000;

	// one read at a time, answered the cycle after the address is taken
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= `RESP_OKAY;
		end else if (s_axi_arvalid & s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
			s_axi_rresp <= ar_ok ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rvalid & s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ==========================================
	// checks
	// ==========================================
	chk_src_follow: assert property (@(posedge sys_clk) disable iff (rst)
		(src_r == lock_sync_pkg::SRC_IEC) && iec_locked |-> act_tick == iec_edge)
		else $error("active tick not from chosen input");
	chk_div_range: assert property (@(posedge sys_clk) disable iff (rst)
		wr_div |=> (div_r >= DIV_LO) && (div_r <= DIV_HI))
		else $error("internal rate left its range");
	chk_mc_range: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(mc_locked) |=> (mc_per >= PER_W'(MC_MIN_PER)) && (mc_per <= PER_W'(MC_MAX_PER)))
		else $error("multichannel lock outside range");
	chk_iec_range: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(iec_locked) |=> (iec_per >= PER_W'(IEC_MIN_PER)) && (iec_per <= PER_W'(IEC_MAX_PER)))
		else $error("iec lock outside range");
	chk_led_flash: assert property (@(posedge sys_clk) disable iff (rst)
		mc_code == lock_sync_pkg::CODE_LOCK ##1 mc_code == lock_sync_pkg::CODE_LOCK
		|-> led_mc == $past(blink_r))
		else $error("locked input led not flashing");
	chk_led_steady: assert property (@(posedge sys_clk) disable iff (rst)
		mc_locked && mc_sync_r |=> led_mc)
		else $error("synchronous input led not steady");
	chk_master_led: assert property (@(posedge sys_clk) disable iff (rst)
		mc_locked && !mc_sync_r && !blink_r |=> !led_sync)
		else $error("master led steady while not synchronous");
	chk_code_none: assert property (@(posedge sys_clk) disable iff (rst)
		s_axi_arvalid && s_axi_arready && hit(s_axi_araddr, `REG_STATUS) && !iec_locked
		|=> s_axi_rdata[`ST_IEC_LSB +: 2] == lock_sync_pkg::CODE_NOLOCK)
		else $error("status shows iec lock without lock");
	chk_sync_count: assert property (@(posedge sys_clk) disable iff (rst)
		win_end && (mc_tot != act_tot) |=> !mc_sync_r [*2])
		else $error("sync declared on count mismatch");
	chk_irq_level: assert property (@(posedge sys_clk) disable iff (rst)
		$stable(irq_mask_r) |-> irq == |(irq_stat_r & irq_mask_r))
		else $error("interrupt does not follow masked status");
endmodule : input_lock_sync_monitor

// ==== hdl/lock_sync_defines.svh ====
`ifndef LOCK_SYNC_DEFINES_SVH
`define LOCK_SYNC_DEFINES_SVH

// ==========================================
// clock and rate figures
// ==========================================
`define CLK_HZ 100000000
`define MC_MIN_HZ 31500
`define MC_MAX_HZ 50000
`define IEC_MIN_HZ 27000
`define IEC_MAX_HZ 200000
`define INT_MIN_HZ 28000
`define INT_MAX_HZ 200000
`define INT_DEF_HZ 48000
`define LOCK_TOL_CYC 16
`define WIN_MS 10
`define BLINK_MS 250
`define MS_PER_S 1000

// ==========================================
// register offsets (byte addresses)
// ==========================================
`define REG_CTRL 8'h00
`define REG_DIV 8'h04
`define REG_STATUS 8'h08
`define REG_IRQ_STAT 8'h0C
`define REG_IRQ_MASK 8'h10
`define REG_MC_PER 8'h14
`define REG_IEC_PER 8'h18

// ==========================================
// field layout and reset values
// ==========================================
`define SRC_W 2
`define ST_MC_LSB 0
`define ST_IEC_LSB 2
`define ST_MSYNC 4
`define ST_ACT_LOCK 5
`define IRQ_MC 0
`define IRQ_IEC 1
`define IRQ_MSYNC 2
`define IRQ_W 3
`define IRQ_MASK_RST 3'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== hdl/lock_sync_pkg.sv ====
package lock_sync_pkg;
	// clock source of the active sample clock
	typedef enum logic [1:0] {
		SRC_INT = 2'h0,
		SRC_MC = 2'h1,
		SRC_IEC = 2'h2
	} src_sel_e;
	// per-input state code shown to software
	typedef enum logic [1:0] {
		CODE_NOLOCK = 2'h0,
		CODE_LOCK = 2'h1,
		CODE_SYNC = 2'h2
	} lock_code_e;
endpackage : lock_sync_pkg

// ==== hdl/rate_meter.sv ====
// measures the period of a recovered frame clock pin and tracks lock
module rate_meter #(
	parameter int MIN_PER = 2000,
	parameter int MAX_PER = 3174,
	parameter int TOL = 16,
	parameter int PER_W = 16
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic pin,
	output logic edge_p,
	output logic locked,
	output logic [PER_W-1:0] period
);
	// ==========================================
	// limits
	// ==========================================
	localparam logic [PER_W-1:0] ACQ_LO = MIN_PER[PER_W-1:0];
	localparam logic [PER_W-1:0] ACQ_HI = MAX_PER[PER_W-1:0];
	localparam int HOLD_LO_I = MIN_PER - TOL;
	localparam int HOLD_HI_I = MAX_PER + TOL;
	localparam logic [PER_W-1:0] HOLD_LO = HOLD_LO_I[PER_W-1:0];
	localparam logic [PER_W-1:0] HOLD_HI = HOLD_HI_I[PER_W-1:0];
	localparam logic [PER_W-1:0] SAT = '1;

	// refuse limits the counter cannot hold
	if (TOL < 0 || MIN_PER <= TOL || MIN_PER > MAX_PER || HOLD_HI_I >= (1 << PER_W) - 1) begin : g_bad
		$error("rate_meter: period limits do not fit");
	end

	// ==========================================
	// pin synchroniser and edge detect
	// ==========================================
	logic s1_r; // first stage, read only by s2_r
	logic s2_r; // settled pin level
	logic s3_r; // delayed level for edge detect
	logic [PER_W-1:0] cnt_r; // cycles since last rising edge
	wire edge_w = s2_r & ~s3_r;
	wire in_acq = (cnt_r >= ACQ_LO) && (cnt_r <= ACQ_HI);
	wire in_hold = (cnt_r >= HOLD_LO) && (cnt_r <= HOLD_HI);
	wire timeout = cnt_r > HOLD_HI;

	// two flops before any logic looks at the pin
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// period counter, saturating while the pin is idle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_r <= SAT;
			period <= '0;
			edge_p <= 1'b0;
		end else begin
			edge_p <= edge_w;
			if (edge_w) begin
				cnt_r <= {{(PER_W-1){1'b0}}, 1'b1};
				period <= cnt_r;
			end else if (cnt_r != SAT) begin
				cnt_r <= cnt_r + 1'b1;
			end
		end
	end

	// acquire inside the range, then hold with a tracking margin
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			locked <= 1'b0;
		end else if (edge_w) begin
			locked <= locked ? in_hold : in_acq;
		end else if (timeout) begin
			locked <= 1'b0;
		end
	end

	// ==========================================
	// checks
	// ==========================================
	chk_acq_range: assert property (@(posedge sys_clk) disable iff (rst)
		!locked && edge_w |=> locked == $past(in_acq))
		else $error("lock acquired outside its range");
	chk_hold_track: assert property (@(posedge sys_clk) disable iff (rst)
		locked && edge_w && in_hold |=> locked [*2])
		else $error("lock dropped on a small drift");
	chk_idle_drop: assert property (@(posedge sys_clk) disable iff (rst)
		timeout && !edge_w |=> !locked)
		else $error("lock kept without input edges");
endmodule : rate_meter

// ==== testbench/link_source.sv ====
// ==========================================
// far-side frame clock source
// ==========================================
module link_source (
	input wire logic en,
	input wire logic [7:0] half_ns,
	output logic clk
);
	timeunit 1ns;
	timeprecision 1ns;
	// the clock rests low between frames so no stale edge reaches the pin
	initial clk = 1'b0;
	// free toggling only while enabled, half period in ns
	always begin
		if (en) begin
			clk = 1'b1;
			#(half_ns);
			clk = 1'b0;
			#(half_ns);
		end else begin
			// start off the system clock's edges so pin sampling has no race
			@(en);
			#3;
		end
	end
endmodule : link_source

// ==== testbench/tb_input_lock_sync_monitor.sv ====
`include "lock_sync_defines.svh"
module tb_input_lock_sync_monitor;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================
	// stimulus and observed signals
	// ==========================================
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic mc_en = 1'b0;
	logic iec_en = 1'b0;
	logic [7:0] mc_half = 8'h32;
	logic [7:0] iec_half = 8'h32;
	logic mc_clk_in, iec_clk_in;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic led_mc, led_iec, led_sync, irq;
	logic [33:0] exp_q[$]; // expected {resp, data} of each bus answer
	int failures = 0;
	int n_checks = 0;
	int seed = 27;
	logic [2:0] m;
	localparam int PER_LO = 12; // shortest accepted link period, system cycles
	localparam int PER_HI = 20; // longest accepted link period, system cycles
	localparam int DIV_LO = 8; // smallest legal internal divider
	localparam int DIV_HI = 40; // largest legal internal divider
	localparam int DIV_MID = 16; // divider after reset, matches the 160 ns link
	int dv[4] = '{7, 41, 8, 40}; // divider values tried
	int de[4] = '{16, 16, 8, 40}; // divider read back after each
	wire [2:0] leds = {led_sync, led_iec, led_mc};
	wire [3:0] hs = {s_axi_rvalid, s_axi_arready, s_axi_bvalid, s_axi_awready & s_axi_wready};
	// 100 MHz system clock
	always #5 sys_clk = ~sys_clk;
	// ==========================================
	// design and far-side sources
	// ==========================================
	input_lock_sync_monitor #(.MC_MIN_PER(PER_LO), .MC_MAX_PER(PER_HI), .IEC_MIN_PER(PER_LO),
		.IEC_MAX_PER(PER_HI), .DIV_MIN(DIV_LO), .DIV_MAX(DIV_HI), .DIV_DEF(DIV_MID), .TOL(2),
		.WIN_CYCLES(2000), .BLINK_CYCLES(64)) u_input_lock_sync_monitor (
		.sys_clk, .rst, .mc_clk_in, .iec_clk_in, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.led_mc, .led_iec, .led_sync, .irq);
	link_source u_mc_src (.en(mc_en), .half_ns(mc_half), .clk(mc_clk_in));
	link_source u_iec_src (.en(iec_en), .half_ns(iec_half), .clk(iec_clk_in));
	// ==========================================
	// checking and reporting
	// ==========================================
	task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
		n_checks++;
		if (s !== e) begin
			$display("ERROR %s expected %h seen %h", n, e, s);
			failures++;
		end
	endtask : chk
	task automatic complete_run();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run
	// bounded wait for a handshake bit, ending on the taking edge
	task automatic wfor(input int k);
		int i;
		i = 0;
		@(negedge sys_clk);
		while (hs[k] !== 1'b1) begin
			if (++i > 200) begin
				failures++;
				complete_run();
			end
			@(negedge sys_clk);
		end
		@(posedge sys_clk);
	endtask : wfor
	// one write: address and data offered together, response awaited
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		exp_q.push_back({r, 32'h0});
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		wfor(0);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		wfor(1);
		s_axi_bready <= 1'b0;
	endtask : wr
	// one read, expected answer noted for the monitor
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		exp_q.push_back({r, d});
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		wfor(2);
		s_axi_arvalid <= 1'b0;
		wfor(3);
		s_axi_rready <= 1'b0;
	endtask : rd
	// indicator mode over 200 cycles: 0 off, 1 flashing, 2 steady on
	task automatic led(input int i, input int st);
		int t;
		logic p;
		t = 0;
		@(negedge sys_clk);
		p = leds[i];
		repeat (200) begin
			@(negedge sys_clk);
			if (leds[i] !== p)
				t++;
			p = leds[i];
		end
		chk("led", 34'((st == 1) ? (t >= 2) : (t == 0 && p === (st == 2))), 34'h1);
	endtask : led
	task automatic irq_is(input logic e);
		repeat (3) @(negedge sys_clk);
		chk("irq", 34'(irq), 34'(e));
	endtask : irq_is
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc
	// monitor: each bus answer takes the oldest note off the queue
	always @(negedge sys_clk) begin
		if (s_axi_rvalid && s_axi_rready)
			chk("read", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
		if (s_axi_bvalid && s_axi_bready)
			chk("bresp", {s_axi_bresp, 32'h0}, exp_q.pop_front());
	end
	// ==========================================
	// main sequence
	// ==========================================
	initial begin
		cyc(3);
		rst <= 1'b0;
		rd(`REG_CTRL, 32'h0, `RESP_OKAY);
		rd(`REG_DIV, 32'h10, `RESP_OKAY);
		rd(`REG_STATUS, 32'h30, `RESP_OKAY);
		rd(`REG_IRQ_MASK, 32'h0, `RESP_OKAY);
		rd(`REG_IRQ_STAT, 32'h0, `RESP_OKAY);
		rd(8'h1C, 32'h0, `RESP_SLVERR);
		wr(8'h1C, 32'h5, `RESP_SLVERR);
		led(2, 2);
		$display("test reset done");
		mc_en <= 1'b1;
		cyc(600);
		rd(`REG_STATUS, 32'h30, `RESP_OKAY);
		mc_half <= 8'd80;
		cyc(5000);
		rd(`REG_STATUS, 32'h32, `RESP_OKAY);
		rd(`REG_MC_PER, 32'h10, `RESP_OKAY);
		led(0, 2);
		led(2, 2);
		$display("test multichannel lock done");
		m = 3'($random(seed));
		wr(`REG_IRQ_MASK, {29'h0, m}, `RESP_OKAY);
		rd(`REG_IRQ_MASK, {29'h0, m}, `RESP_OKAY);
		wr(`REG_IRQ_MASK, 32'h7, `RESP_OKAY);
		wr(`REG_IRQ_STAT, 32'h7, `RESP_OKAY);
		rd(`REG_IRQ_STAT, 32'h0, `RESP_OKAY);
		irq_is(1'b0);
		iec_half <= 8'd85;
		iec_en <= 1'b1;
		cyc(5000);
		rd(`REG_STATUS, 32'h26, `RESP_OKAY);
		led(1, 1);
		led(2, 1);
		rd(`REG_IRQ_STAT, 32'h6, `RESP_OKAY);
		irq_is(1'b1);
		wr(`REG_IRQ_MASK, 32'h0, `RESP_OKAY);
		irq_is(1'b0);
		wr(`REG_IRQ_MASK, 32'h2, `RESP_OKAY);
		irq_is(1'b1);
		wr(`REG_IRQ_STAT, 32'h6, `RESP_OKAY);
		irq_is(1'b0);
		$display("test unsynchronised input done");
		for (int k = 0; k < 4; k++) begin
			wr(`REG_CTRL, k, `RESP_OKAY);
			rd(`REG_CTRL, (k == 3) ? 32'h2 : k, `RESP_OKAY);
		end
		for (int k = 0; k < 4; k++) begin
			wr(`REG_DIV, dv[k], `RESP_OKAY);
			rd(`REG_DIV, de[k], `RESP_OKAY);
		end
		// only the low byte is enabled: upper bytes keep the stored divider
		s_axi_wstrb <= 4'h1;
		wr(`REG_DIV, 32'hFFFF_FF20, `RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		rd(`REG_DIV, 32'h20, `RESP_OKAY);
		wr(`REG_DIV, 32'h10, `RESP_OKAY);
		wr(`REG_CTRL, 32'h0, `RESP_OKAY);
		$display("test source and rate done");
		iec_en <= 1'b0;
		mc_half <= 8'd105;
		cyc(5000);
		rd(`REG_STATUS, 32'h21, `RESP_OKAY);
		led(0, 1);
		mc_en <= 1'b0;
		iec_half <= 8'd150;
		iec_en <= 1'b1;
		cyc(3000);
		rd(`REG_STATUS, 32'h30, `RESP_OKAY);
		led(0, 0);
		led(2, 2);
		$display("test drift and range done");
		complete_run();
	end
endmodule : tb_input_lock_sync_monitor
